// >>> kms_defs.vh
// constants shared by the keyboard matrix scanner files
`ifndef KMS_DEFS_VH
`define KMS_DEFS_VH
`define KMS_CLK_PERIOD_NS 10
`define KMS_SCAN_PERIOD_NS 10000000
`define KMS_SETTLE_NS 1000
`define KMS_BIT_NS 1000
`define KMS_SCAN_ROWS 9
`define KMS_RET_LINES 8
`define KMS_DEC_OUTS 10
`define KMS_CFG_ROW 4'h8
`define KMS_LAST_ROW 4'h8
`define KMS_BUF_DEPTH 7
`define KMS_FRAME_BITS 9
`define KMS_TYPE_KEY 1'b0
`define KMS_TYPE_CFG 1'b1
`define KMS_MAKE_HI 4'hb
`define KMS_BREAK_HI 4'ha
`define KMS_KEY_43 7'h2b
`define KMS_KEY_57 7'h39
`define KMS_KEY_68 7'h44
`define KMS_KEY_69 7'h45
`define KMS_KEY_70 7'h46
`define KMS_KEY_72 7'h48
`define KMS_NOREP_LO 7'h02
`define KMS_NOREP_HI 7'h09
`define KMS_LOCK_43 3'h2
`define KMS_LOCK_57 3'h3
`define KMS_LOCK_70 3'h4
`define KMS_LOCK_72 3'h5
`define KMS_LOCK_68 3'h6
`define KMS_LOCK_69 3'h7
`define KMS_LOCK_NONE 3'h0
`endif

// >>> kms_ser_tx.v
// bit-serial frame sender toward the serial-to-parallel port
`timescale 1ns/1ps
`include "kms_defs.vh"
module kms_ser_tx #(
  parameter BIT_CYCLES = `KMS_BIT_NS / `KMS_CLK_PERIOD_NS
) (
  input wire clk_i,
  input wire rstn_i,
  input wire start_i,
  input wire [8:0] word_i,
  output reg busy_o,
  output reg ser_data_o,
  output reg ser_clk_o,
  output reg ser_frame_o
);
  localparam integer BIT_LAST_I = BIT_CYCLES - 1;
  localparam integer BIT_HALF_I = BIT_CYCLES / 2;
  localparam [15:0] BIT_LAST = BIT_LAST_I[15:0];
  localparam [15:0] BIT_HALF = BIT_HALF_I[15:0];
  reg [8:0] sh_q;
  reg [3:0] left_q;
  reg [15:0] tick_q;

  // msb first, bit valid while ser_clk rises in its middle
  always @(posedge clk_i) begin
    if (!rstn_i) begin
      busy_o <= 1'b0;
      ser_data_o <= 1'b0;
      ser_clk_o <= 1'b0;
      ser_frame_o <= 1'b0;
      sh_q <= 9'h000;
      left_q <= 4'h0;
      tick_q <= 16'h0000;
    end else if (!busy_o) begin
      if (start_i) begin
        busy_o <= 1'b1;
        ser_frame_o <= 1'b1;
        ser_data_o <= word_i[8];
        sh_q <= {word_i[7:0], 1'b0};
        left_q <= 4'h8;
        tick_q <= 16'h0000;
      end
    end else begin
      tick_q <= tick_q + 16'h0001;
      if (tick_q == BIT_HALF)
        ser_clk_o <= 1'b1;
      if (tick_q == BIT_LAST) begin
        ser_clk_o <= 1'b0;
        tick_q <= 16'h0000;
        if (left_q == 4'h0) begin
          ser_frame_o <= 1'b0;
          ser_data_o <= 1'b0;
          busy_o <= 1'b0;
        end else begin
          ser_data_o <= sh_q[8];
          sh_q <= {sh_q[7:0], 1'b0};
          left_q <= left_q - 4'h1;
        end
      end
    end
  end
endmodule // kms_ser_tx

// >>> kms_scanner.v
// keyboard matrix scanner: scan, key decision, code buffer and serial output
// How it works
// - matrix of nine scan lines by eight return lines, one switch per crossing.
// - idle holds every scan line low so any press pulls a return low.
// - a low return starts a row-by-row scan; key is row crossing column.
// - decoder turns a 4-bit select, A lowest, into one low output of ten.
// - the decoder makes scan lines 0 to 8 from row_q, the row also driven on the four select outputs.
// - two or more keys in one 10 ms scan is an error until one or none remains.
// - lock keys give a make code on first press, break on the next.
// - an ordinary key gives its code once, when pressed.
// - auto repeat re-sends a held key; enable and rate come from software.
// - keys 2 to 9, 43, 57, 68, 69, 70, 72 never repeat.
// - up to seven codes wait in a buffer when transfer is held off.
// - the config switch bank on scan line 8 is read like keys.
// - config switches are read with the keys at initialisation.
// - keys and switch settings go bit-serially to the receiving port.
`timescale 1ns/1ps
`include "kms_defs.vh"
module kms_scanner #(
  parameter SCAN_CYCLES = `KMS_SCAN_PERIOD_NS / `KMS_CLK_PERIOD_NS,
  parameter SETTLE_CYCLES = `KMS_SETTLE_NS / `KMS_CLK_PERIOD_NS,
  parameter BIT_CYCLES = `KMS_BIT_NS / `KMS_CLK_PERIOD_NS,
  parameter BUF_DEPTH = `KMS_BUF_DEPTH
) (
  input wire clk_i,
  input wire rstn_i,
  input wire [7:0] key_return_line_n_i,
  input wire auto_repeat_en_i,
  input wire [7:0] repeat_rate_i,
  input wire ser_ready_i,
  output reg [3:0] scan_sel_o,
  output reg [8:0] key_scan_line_n_o,
  output wire ser_data_o,
  output wire ser_clk_o,
  output wire ser_frame_o,
  output reg multi_key_err_o,
  output reg [7:0] config_switch_bank_o
);
  localparam [4:0] ST_IDLE = 5'b00001;
  localparam [4:0] ST_SCAN = 5'b00010;
  localparam [4:0] ST_CFG = 5'b00100;
  localparam [4:0] ST_EVAL = 5'b01000;
  localparam [4:0] ST_WAIT = 5'b10000;
  localparam integer SCAN_LAST_I = SCAN_CYCLES - 1;
  localparam integer SETTLE_LAST_I = SETTLE_CYCLES - 1;
  localparam integer BUF_LAST_I = BUF_DEPTH - 1;
  localparam integer BUF_FULL_I = BUF_DEPTH;
  // settle counter and buffer pointers are narrower than integer, so their constants are cut on purpose
  localparam [31:0] SCAN_LAST = SCAN_LAST_I[31:0];
  localparam [15:0] SETTLE_LAST = SETTLE_LAST_I[15:0];
  localparam [2:0] BUF_LAST = BUF_LAST_I[2:0];
  localparam [3:0] BUF_FULL = BUF_FULL_I[3:0];

  // one-low 4-to-10 decode, select bit 0 is input A
  function [9:0] dec_one_low;
    input [3:0] sel;
    integer i;
    begin
      dec_one_low = 10'h3ff;
      for (i = 0; i < `KMS_DEC_OUTS; i = i + 1)
        if (sel == i[3:0])
          dec_one_low[i] = 1'b0;
    end
  endfunction

  function [1:0] count_sat;
    input [7:0] v;
    integer i;
    reg [3:0] n;
    begin
      n = 4'h0;
      for (i = 0; i < `KMS_RET_LINES; i = i + 1)
        n = n + {3'h0, v[i]};
      count_sat = (n > 4'h2) ? 2'h2 : n[1:0];
    end
  endfunction

  function [2:0] col_of;
    input [7:0] v;
    integer i;
    begin
      col_of = 3'h0;
      for (i = 0; i < `KMS_RET_LINES; i = i + 1)
        if (v[i])
          col_of = i[2:0];
    end
  endfunction

  // key number is position plus one
  function [2:0] lock_idx;
    input [6:0] num;
    begin
      case (num)
        `KMS_KEY_43: lock_idx = `KMS_LOCK_43;
        `KMS_KEY_57: lock_idx = `KMS_LOCK_57;
        `KMS_KEY_70: lock_idx = `KMS_LOCK_70;
        `KMS_KEY_72: lock_idx = `KMS_LOCK_72;
        `KMS_KEY_68: lock_idx = `KMS_LOCK_68;
        `KMS_KEY_69: lock_idx = `KMS_LOCK_69;
        default: lock_idx = `KMS_LOCK_NONE;
      endcase
    end
  endfunction

  function no_repeat;
    input [6:0] num;
    begin
      no_repeat = ((num >= `KMS_NOREP_LO) && (num <= `KMS_NOREP_HI)) ||
        (lock_idx(num) != `KMS_LOCK_NONE);
    end
  endfunction

  function [2:0] ptr_next;
    input [2:0] p;
    begin
      ptr_next = (p == BUF_LAST) ? 3'h0 : p + 3'h1;
    end
  endfunction

  // rescan period counts down in the idle, scan and wait states and rests at zero
  function [31:0] count_down;
    input [31:0] v;
    begin
      count_down = (v == 32'h0000_0000) ? v : v - 32'h0000_0001;
    end
  endfunction

  reg [4:0] state_q;
  reg [3:0] row_q;
  reg [15:0] settle_q;
  reg [31:0] period_q;
  reg [1:0] hits_q;
  reg [5:0] pos_q;
  reg [5:0] last_pos_q;
  reg held_q;
  reg init_q;
  reg [7:0] rep_q;
  reg [7:0] lock_q;
  reg [8:0] mem_q [0:BUF_DEPTH-1];
  reg [2:0] wr_q;
  reg [2:0] rd_q;
  reg [3:0] cnt_q;
  reg push_d;
  reg [8:0] push_word_d;
  wire tx_busy;
  wire pop;
  wire [7:0] pressed;
  wire [6:0] key_num;
  wire [2:0] lk;
  wire new_press;
  wire [9:0] row_dec;

  assign pressed = ~key_return_line_n_i;
  assign key_num = {1'b0, pos_q} + 7'h01;
  assign lk = lock_idx(key_num);
  assign new_press = !held_q || (pos_q != last_pos_q);
  assign row_dec = dec_one_low(row_q);
  assign pop = (cnt_q != 4'h0) && !tx_busy && ser_ready_i;

  // key code chosen at evaluation, config code in ST_CFG; at most one key code per scan
  always @* begin
    push_d = 1'b0;
    push_word_d = 9'h000;
    if (state_q == ST_CFG) begin
      push_d = 1'b1;
      push_word_d = {`KMS_TYPE_CFG, config_switch_bank_o};
    end else if (state_q == ST_EVAL && hits_q == 2'h1) begin
      if (new_press) begin
        push_d = 1'b1;
        if (lk != `KMS_LOCK_NONE)
          push_word_d = {`KMS_TYPE_KEY, lock_q[lk] ? `KMS_BREAK_HI : `KMS_MAKE_HI,
            1'b0, lk};
        else
          push_word_d = {`KMS_TYPE_KEY, 2'h0, pos_q};
      // a rate of zero reloads zero, so it must fire like a rate of one
      end else if (auto_repeat_en_i && !no_repeat(key_num) && rep_q <= 8'h01) begin
        push_d = 1'b1;
        push_word_d = {`KMS_TYPE_KEY, 2'h0, pos_q};
      end
    end
  end

  always @(posedge clk_i) begin
    if (!rstn_i) begin
      state_q <= ST_IDLE;
      row_q <= 4'h0;
      settle_q <= 16'h0000;
      period_q <= 32'h0000_0000;
      hits_q <= 2'h0;
      pos_q <= 6'h00;
      last_pos_q <= 6'h00;
      held_q <= 1'b0;
      init_q <= 1'b1;
      rep_q <= 8'h00;
      lock_q <= 8'h00;
      scan_sel_o <= 4'h0;
      key_scan_line_n_o <= 9'h000;
      multi_key_err_o <= 1'b0;
      config_switch_bank_o <= 8'h00;
    end else begin
      case (state_q)
        ST_IDLE: begin
          key_scan_line_n_o <= 9'h000;
          period_q <= count_down(period_q);
          if (init_q || (!held_q && !multi_key_err_o && pressed != 8'h00) ||
              ((held_q || multi_key_err_o) && period_q == 32'h0000_0000)) begin
            state_q <= ST_SCAN;
            row_q <= 4'h0;
            settle_q <= 16'h0000;
            hits_q <= 2'h0;
            period_q <= SCAN_LAST;
          end
        end
        ST_SCAN: begin
          period_q <= count_down(period_q);
          scan_sel_o <= row_q;
          key_scan_line_n_o <= row_dec[8:0];
          settle_q <= settle_q + 16'h0001;
          if (settle_q == SETTLE_LAST) begin
            settle_q <= 16'h0000;
            if (row_q == `KMS_CFG_ROW) begin
              if (init_q)
                config_switch_bank_o <= pressed;
              state_q <= init_q ? ST_CFG : ST_EVAL;
            end else begin
              if (count_sat(pressed) != 2'h0) begin
                pos_q <= {row_q[2:0], col_of(pressed)};
                hits_q <= (hits_q + count_sat(pressed) > 2'h2 || hits_q[1]) ? 2'h2 :
                  hits_q + count_sat(pressed);
              end
              row_q <= row_q + 4'h1;
            end
          end
        end
        ST_CFG: begin
          init_q <= 1'b0;
          state_q <= ST_EVAL;
        end
        ST_EVAL: begin
          state_q <= ST_WAIT;
          if (hits_q == 2'h2) begin
            multi_key_err_o <= 1'b1;
            held_q <= 1'b0;
          end else if (hits_q == 2'h1) begin
            multi_key_err_o <= 1'b0;
            held_q <= 1'b1;
            last_pos_q <= pos_q;
            if (new_press) begin
              rep_q <= repeat_rate_i;
              if (lk != `KMS_LOCK_NONE)
                lock_q[lk] <= ~lock_q[lk];
            end else if (auto_repeat_en_i && !no_repeat(key_num)) begin
              rep_q <= (rep_q <= 8'h01) ? repeat_rate_i : rep_q - 8'h01;
            end
          end else begin
            multi_key_err_o <= 1'b0;
            held_q <= 1'b0;
          end
        end
        ST_WAIT: begin
          // one cycle so the return lines see all scan lines low again
          key_scan_line_n_o <= 9'h000;
          period_q <= count_down(period_q);
          state_q <= ST_IDLE;
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // code buffer; a code arriving while full is dropped unless a pop frees a slot in the same cycle, oldest kept
  always @(posedge clk_i) begin
    if (!rstn_i) begin
      wr_q <= 3'h0;
      rd_q <= 3'h0;
      cnt_q <= 4'h0;
    end else begin
      if (push_d && (cnt_q != BUF_FULL || pop)) begin
        mem_q[wr_q] <= push_word_d;
        wr_q <= ptr_next(wr_q);
      end
      if (pop)
        rd_q <= ptr_next(rd_q);
      if (push_d && (cnt_q != BUF_FULL || pop) && !pop)
        cnt_q <= cnt_q + 4'h1;
      else if (pop && !push_d)
        cnt_q <= cnt_q - 4'h1;
    end
  end

  kms_ser_tx #(
    .BIT_CYCLES(BIT_CYCLES)
  ) u_tx (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .start_i(pop),
    .word_i(mem_q[rd_q]),
    .busy_o(tx_busy),
    .ser_data_o(ser_data_o),
    .ser_clk_o(ser_clk_o),
    .ser_frame_o(ser_frame_o)
  );
endmodule // kms_scanner

// >>> kms_scanner_checker.sv
// port assertions for the keyboard matrix scanner
`timescale 1ns/1ps
module kms_scanner_checker #(
  parameter BIT_CYCLES = 4
) (
  input wire clk_i,
  input wire rstn_i,
  input wire ser_ready_i,
  input wire [3:0] scan_sel_o,
  input wire [8:0] key_scan_line_n_o,
  input wire ser_data_o,
  input wire ser_clk_o,
  input wire ser_frame_o
);
  reg [15:0] fcnt_q;
  always @(posedge clk_i) begin
    if (!rstn_i || !ser_frame_o) fcnt_q <= 16'h0000;
    else fcnt_q <= fcnt_q + 16'h0001;
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  // shape written for BIT_CYCLES of 4: high only in the last tick of the bit
  sequence clk_half;
    ser_clk_o ##1 !ser_clk_o;
  endsequence
  a_line_follows_sel: assert property (key_scan_line_n_o != 9'h000 |->
    key_scan_line_n_o == ~(9'h001 << scan_sel_o)) else $error("scan line not select");
  a_sel_in_range: assert property (scan_sel_o <= 4'h8) else $error("select past row 8");
  a_rows_in_order: assert property ($changed(scan_sel_o) |->
    scan_sel_o == $past(scan_sel_o) + 4'h1 || scan_sel_o == 4'h0) else $error("row skipped");
  a_start_when_ready: assert property ($rose(ser_frame_o) |-> $past(ser_ready_i))
    else $error("frame without ready");
  a_frame_gap: assert property ($fell(ser_frame_o) |-> !ser_clk_o && !ser_data_o)
    else $error("line not idle after frame");
  a_frame_length: assert property ($fell(ser_frame_o) |-> fcnt_q == 9 * BIT_CYCLES)
    else $error("frame length wrong");
  a_clk_in_frame: assert property (ser_clk_o |-> ser_frame_o) else $error("clock off frame");
  a_clk_shape: assert property ($rose(ser_clk_o) |-> clk_half) else $error("bit clock shape");
  a_data_steady: assert property ($rose(ser_clk_o) |-> $stable(ser_data_o))
    else $error("data moved under clock");
endmodule // kms_scanner_checker
bind kms_scanner kms_scanner_checker #(.BIT_CYCLES(BIT_CYCLES)) chk_u (
  .clk_i(clk_i),
  .rstn_i(rstn_i),
  .ser_ready_i(ser_ready_i),
  .scan_sel_o(scan_sel_o),
  .key_scan_line_n_o(key_scan_line_n_o),
  .ser_data_o(ser_data_o),
  .ser_clk_o(ser_clk_o),
  .ser_frame_o(ser_frame_o)
);

// >>> kms_rx_model.sv
// serial receiver model that rebuilds nine-bit frames
`timescale 1ns/1ps
module kms_rx_model (
  input wire clk_i,
  input wire stall_i,
  input wire ser_data_i,
  input wire ser_clk_i,
  input wire ser_frame_i,
  output wire ser_ready_o,
  output reg got_o,
  output reg [8:0] word_o
);
  reg clk_q;
  reg frame_q;
  reg [8:0] sh_q;
  assign ser_ready_o = !stall_i;
  always @(posedge clk_i) begin
    clk_q <= ser_clk_i;
    frame_q <= ser_frame_i;
    got_o <= frame_q && !ser_frame_i;
    // shift on the rising bit clock, msb arrives first
    if (!ser_frame_i) sh_q <= 9'h000;
    else if (ser_clk_i && !clk_q) sh_q <= {sh_q[7:0], ser_data_i};
    if (frame_q && !ser_frame_i) word_o <= sh_q;
  end
endmodule // kms_rx_model

// >>> kms_scanner_tb.sv
// self-checking bench for the keyboard matrix scanner
`timescale 1ns/1ps
module kms_scanner_tb;
  logic clk_i, rstn_i, rep_en, stall, rx_got, ser_ready, sd, sc, sf, err;
  logic [7:0] rate, ret_n, cfg;
  logic [3:0] sel;
  logic [8:0] lines_n, rx_word;
  logic [71:0] keys;
  logic [8:0] rxq[$];
  int n_mismatch, cmp_count, cyc_n;
  kms_scanner #(.SCAN_CYCLES(200), .SETTLE_CYCLES(4), .BIT_CYCLES(4)) dut_u (
    .clk_i(clk_i), .rstn_i(rstn_i), .key_return_line_n_i(ret_n),
    .auto_repeat_en_i(rep_en), .repeat_rate_i(rate), .ser_ready_i(ser_ready),
    .scan_sel_o(sel), .key_scan_line_n_o(lines_n), .ser_data_o(sd), .ser_clk_o(sc),
    .ser_frame_o(sf), .multi_key_err_o(err), .config_switch_bank_o(cfg));
  kms_rx_model rx_u (.clk_i(clk_i), .stall_i(stall), .ser_data_i(sd), .ser_clk_i(sc),
    .ser_frame_i(sf), .ser_ready_o(ser_ready), .got_o(rx_got), .word_o(rx_word));
  // switch matrix: a closed switch on a low scan line pulls its return low
  always @* begin
    ret_n = 8'hff;
    for (int k = 0; k < 9; k++) if (!lines_n[k]) ret_n = ret_n & ~keys[k*8 +: 8];
  end
  always @(posedge clk_i) if (rx_got === 1'b1) rxq.push_back(rx_word);
  initial begin
    clk_i = 0;
    forever #5 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    cyc_n++;
    if (cyc_n == 20000) begin
      n_mismatch++;
      complete_run;
    end
  end
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_i);
  endtask
  task automatic chk(input string nm, input logic [8:0] e, input logic [8:0] g);
    cmp_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic take(input logic [8:0] e);
    chk("frame", e, rxq.size() ? rxq.pop_front() : 9'bx);
  endtask
  task automatic none_left;
    chk("frames left", 9'h000, 9'(rxq.size()));
  endtask
  task automatic hold(input int p, input int n);
    keys[p] = 1'b1;
    cyc(n);
    keys[p] = 1'b0;
    cyc(300);
  endtask
  task automatic t_init;
    take(9'h1a5);
    chk("config", 9'h0a5, {1'b0, cfg});
    keys[71:64] = 8'h00;
    cyc(300);
    none_left();
    chk("idle lines", 9'h000, lines_n);
  endtask
  task automatic t_key;
    hold(10, 700);
    take(9'h00a);
    none_left();
  endtask
  task automatic t_lock;
    rep_en = 1'b1;
    hold(42, 700);
    hold(42, 300);
    take(9'h0b2);
    take(9'h0a2);
    none_left();
    rep_en = 1'b0;
  endtask
  task automatic t_multi;
    keys[5] = 1'b1;
    keys[20] = 1'b1;
    cyc(300);
    chk("error", 9'h001, {8'h00, err});
    none_left();
    keys[20] = 1'b0;
    cyc(400);
    chk("error", 9'h000, {8'h00, err});
    take(9'h005);
    keys[5] = 1'b0;
    cyc(300);
  endtask
  task automatic t_repeat;
    rep_en = 1'b1;
    hold(20, 700);
    take(9'h014);
    chk("repeated", 9'h001, {8'h00, rxq.size() > 0});
    take(9'h014);
    rxq.delete();
    hold(4, 700);
    take(9'h004);
    none_left();
    rep_en = 1'b0;
  endtask
  task automatic t_buffer;
    stall = 1'b1;
    for (int i = 0; i < 8; i++) hold(30 + i, 300);
    stall = 1'b0;
    cyc(400);
    for (int i = 0; i < 7; i++) take(9'(30 + i));
    none_left();
  endtask
  task complete_run;
    if (n_mismatch == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    rstn_i = 0;
    rep_en = 0;
    rate = 8'h01;
    stall = 0;
    keys = {8'ha5, 64'h0};
    cyc(5);
    rstn_i = 1;
    cyc(300);
    t_init();
    t_key();
    t_lock();
    t_multi();
    t_repeat();
    t_buffer();
    complete_run;
  end
endmodule // kms_scanner_tb
